// File: hdl/sld_axis_ctrl.sv
// Axis top: registers, pulse generator, soft limits, step loss check.
// Assumes one AHB-Lite master, a step/dir motor driver and an encoder.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps

module sld_axis_ctrl import sld_pkg::*; #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Motor driver
  output logic stepOut,
  output logic dirOut,
  output logic busy,
  // Encoder feedback
  input wire logic fbPhaseA,
  input wire logic fbPhaseB,
  // Interrupt
  output logic intReq_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] env2_r, env4_r, irqEn_r, hrdata_r;
  logic signed [W-1:0] cmp1_r, cmp2_r, cmp3_r, posCnt_r, deflCnt_r;
  logic wrPend_r, fbErrFlag_r, dir_r, high_r, step_r, busy_r;
  logic intReq_n_r;
  logic [7:0] addrPh_r;
  logic [2:0] stopCause_r;
  logic [15:0] timer_r;
  logic [3:0] decelCnt_r;
  sld_state_t state_r, state_nxt;
  sld_fb_evt_t fbEvt;

  function automatic logic regIs(input logic [31:0] a,
                                 input logic [7:0] ofs);
    regIs = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Zero wait state: writes land in the data phase, reads are
  // looked up in the address phase and registered
  wire accept = hsel & htrans[1] & hready;
  wire rdAcc = accept & !hwrite;
  wire [31:0] wrAddr = {24'h00_0000, addrPh_r};
  wire cmdWr = wrPend_r & regIs(wrAddr, OFS_CMD);
  wire [7:0] cmdCode = hwdata[7:0];
  wire cmdDir = hwdata[CMD_DIR_POS];
  wire cmdHigh = (cmdCode == CMD_HIGH_A) | (cmdCode == CMD_HIGH_B);
  wire cmdStart = cmdHigh | (cmdCode == CMD_CONST_A) |
                  (cmdCode == CMD_CONST_B);
  wire deflClr = cmdWr & (cmdCode == CMD_DEFL_CLR);
  wire stopCmd = cmdWr & (cmdCode == CMD_STOP);
  wire stRead = rdAcc & regIs(haddr, OFS_ERRST);
  wire [31:0] errWord = {15'h0000, fbErrFlag_r, 13'h0000, stopCause_r};
  wire [31:0] rdMux =
    regIs(haddr, OFS_CMP1) ? 32'(cmp1_r) :
    regIs(haddr, OFS_CMP2) ? 32'(cmp2_r) :
    regIs(haddr, OFS_CMP3) ? 32'(cmp3_r) :
    regIs(haddr, OFS_IRQEN) ? irqEn_r :
    regIs(haddr, OFS_ERRST) ? errWord :
    regIs(haddr, OFS_POS) ? 32'(posCnt_r) :
    regIs(haddr, OFS_DEFL) ? 32'(deflCnt_r) : 32'h0000_0000;

  // Address phase capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      addrPh_r <= 8'h00;
      hrdata_r <= REG_RST;
    end else begin
      wrPend_r <= accept & hwrite & (haddr[31:8] == 24'h00_0000);
      addrPh_r <= haddr[7:0];
      if (rdAcc) begin
        hrdata_r <= rdMux;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      env2_r <= REG_RST;
      env4_r <= REG_RST;
      irqEn_r <= REG_RST;
      cmp1_r <= '0;
      cmp2_r <= '0;
      cmp3_r <= '0;
    end else if (wrPend_r) begin
      if (addrPh_r == OFS_ENV2) env2_r <= hwdata;
      if (addrPh_r == OFS_ENV4) env4_r <= hwdata;
      if (addrPh_r == OFS_IRQEN) irqEn_r <= hwdata;
      if (addrPh_r == OFS_CMP1) cmp1_r <= W'(hwdata);
      if (addrPh_r == OFS_CMP2) cmp2_r <= W'(hwdata);
      if (addrPh_r == OFS_CMP3) cmp3_r <= W'(hwdata);
    end
  end

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  sld_cmp_cfg_t cfg [3];
  logic signed [W-1:0] cmpCnt [3];
  logic signed [W-1:0] cmpVal [3];
  logic [2:0] hit;

  assign cfg[0] = '{env4_r[C1S_POS +: 3], env4_r[C1D_POS +: 2]};
  assign cfg[1] = '{env4_r[C2S_POS +: 3], env4_r[C2D_POS +: 2]};
  assign cfg[2] = '{env4_r[C3S_POS +: 3], env4_r[C3D_POS +: 2]};
  assign cmpCnt[0] = posCnt_r;
  assign cmpCnt[1] = posCnt_r;
  assign cmpCnt[2] = deflCnt_r;
  assign cmpVal[0] = cmp1_r;
  assign cmpVal[1] = cmp2_r;
  assign cmpVal[2] = cmp3_r;

  // Comparator two is the only one guarding negative travel
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gCmp
      sld_cmp #(.W(W), .GUARD_POS(gi != 1)) uCmp (
        .counter(cmpCnt[gi]),
        .value(cmpVal[gi]),
        .cfg(cfg[gi]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Stop decision
  // ----------------------------------------------------------------
  wire moving = state_r != ST_IDLE;
  wire lim1On = hit[0] & (cfg[0].method == METH_LIMIT);
  wire lim2On = hit[1] & (cfg[1].method == METH_LIMIT);
  wire c1Trip = lim1On & dir_r & (cfg[0].action != ACT_NONE);
  wire c2Trip = lim2On & !dir_r & (cfg[1].action != ACT_NONE);
  wire c3Trip = hit[2] & (cfg[2].action != ACT_NONE);
  // Decel only for decel action while in a high-speed start
  wire c1Imm = c1Trip & ((cfg[0].action != ACT_DECEL) | !high_r);
  wire c2Imm = c2Trip & ((cfg[1].action != ACT_DECEL) | !high_r);
  wire c3Imm = c3Trip & ((cfg[2].action != ACT_DECEL) | !high_r);
  wire immStop = moving & (c1Imm | c2Imm | c3Imm | stopCmd);
  wire decStop = moving & (c1Trip | c2Trip | c3Trip);
  // Start toward an active limit is dropped without notice
  wire blocked = (cmdDir & lim1On) | (!cmdDir & lim2On);
  wire startOk = cmdWr & cmdStart & !blocked;
  wire [15:0] period = 16'(STEP_CYCLES - 1) +
                       16'(DECEL_STRETCH) * 16'(decelCnt_r);
  wire stepNow = moving & (timer_r == 16'h0000) & !immStop;
  wire decelDone = stepNow & (decelCnt_r == 4'(DECEL_STEPS - 1));

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (startOk) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (immStop) state_nxt = ST_IDLE;
        else if (decStop) state_nxt = ST_DECEL;
      end
      ST_DECEL: begin
        if (immStop | decelDone) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Motion sequencer and step timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      dir_r <= 1'b0;
      high_r <= 1'b0;
      timer_r <= 16'h0000;
      decelCnt_r <= 4'h0;
      step_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r <= stepNow;
      // Follows the state register, so the pin needs no decode
      busy_r <= state_nxt != ST_IDLE;
      if (state_r == ST_IDLE && startOk) begin
        dir_r <= cmdDir;
        high_r <= cmdHigh;
        decelCnt_r <= 4'h0;
        timer_r <= 16'(STEP_CYCLES - 1);
      end else if (stepNow) begin
        timer_r <= period;
        if (state_r == ST_DECEL) decelCnt_r <= decelCnt_r + 4'h1;
      end else if (timer_r != 16'h0000) begin
        timer_r <= timer_r - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  sld_fb_decode uDec (
    .ref_clk(ref_clk),
    .rst(rst),
    .fbMode(env2_r[EIM_POS +: 2]),
    .fbDirB(env2_r[EDIR_POS]),
    .fbPhaseA(fbPhaseA),
    .fbPhaseB(fbPhaseB),
    .evt(fbEvt)
  );

  // Deflection is commanded steps minus encoder counts
  wire signed [2:0] deflDelta = 3'(stepNow & dir_r) -
                                3'(stepNow & !dir_r) -
                                3'(fbEvt.up) + 3'(fbEvt.dn);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      posCnt_r <= '0;
      deflCnt_r <= '0;
    end else begin
      if (stepNow) posCnt_r <= dir_r ? posCnt_r + 1'b1 : posCnt_r - 1'b1;
      if (deflClr) deflCnt_r <= '0;
      else deflCnt_r <= deflCnt_r + W'(deflDelta);
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  // Read clears the sticky bits, but a new event in that cycle wins
  wire [2:0] causeSet = {hit[2], c2Trip, c1Trip};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fbErrFlag_r <= 1'b0;
      stopCause_r <= 3'h0;
      intReq_n_r <= 1'b1;
    end else begin
      fbErrFlag_r <= fbEvt.err | (fbErrFlag_r & !stRead);
      stopCause_r <= causeSet | (stopCause_r & {3{!stRead}});
      // Stored inverted so the pin leaves straight from a flop
      intReq_n_r <= !(fbErrFlag_r |
                      (irqEn_r[IRQ_CMP3_POS] & stopCause_r[2]));
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1 | rst;
  assign hresp = 1'b0 & rst;
  assign stepOut = step_r;
  assign dirOut = dir_r;
  assign busy = busy_r;
  assign intReq_n = intReq_n_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_defl_clear: assert property (@(posedge ref_clk) disable iff (rst)
    deflClr |=> deflCnt_r == '0) else $error("deflection not cleared");

  chk_limit_refuse: assert property (@(posedge ref_clk) disable iff (rst)
    (!moving && cmdWr && cmdStart && cmdDir && lim1On) |=> !busy)
    else $error("start toward active limit accepted");

  chk_pos_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_RUN && lim1On && dir_r && cfg[0].action == ACT_IMMED)
    |=> state_r == ST_IDLE) else $error("positive limit did not stop");

  chk_neg_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_RUN && lim2On && !dir_r && cfg[1].action == ACT_IMMED)
    |=> state_r == ST_IDLE) else $error("negative limit did not stop");

  chk_decel_entry: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_RUN && high_r && decStop && !immStop)
    |=> state_r == ST_DECEL) else $error("decel stop not entered");

  chk_const_immed: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_RUN && !high_r && decStop) |=> !busy)
    else $error("constant speed did not stop at once");

  chk_step_loss: assert property (@(posedge ref_clk) disable iff (rst)
    (moving && hit[2] && cfg[2].action == ACT_IMMED) |=> !busy ##1 !busy)
    else $error("step loss did not stop axis");

  chk_err_flag: assert property (@(posedge ref_clk) disable iff (rst)
    fbEvt.err |=> fbErrFlag_r) else $error("feedback error not flagged");

  chk_err_int: assert property (@(posedge ref_clk) disable iff (rst)
    fbEvt.err |-> ##2 !intReq_n) else $error("error interrupt missing");

  chk_cmp3_int: assert property (@(posedge ref_clk) disable iff (rst)
    (irqEn_r[IRQ_CMP3_POS] && hit[2]) |-> ##2 !intReq_n)
    else $error("comparator three interrupt missing");

  chk_pos_count: assert property (@(posedge ref_clk) disable iff (rst)
    (stepNow && dir_r) |=> posCnt_r == $past(posCnt_r) + 1)
    else $error("position did not advance");

endmodule

// File: hdl/sld_cmp.sv
// One position comparator: limit or greater-than test on a counter.
// Assumes counter and value are signed, same clock domain, no latency.
`timescale 1ns/100ps
module sld_cmp import sld_pkg::*; #(
  parameter int W = 32,
  parameter bit GUARD_POS = 1'b1
) (
  // Compared quantities
  input wire logic signed [W-1:0] counter,
  input wire logic signed [W-1:0] value,
  input wire sld_cmp_cfg_t cfg,
  // Result
  output logic hit
);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // Limit stays on until the counter is back inside the value
  wire limPos = counter >= value;
  wire limNeg = counter <= value;
  wire limHit = GUARD_POS ? limPos : limNeg;
  wire gtHit = value < counter;

  assign hit = (cfg.method == METH_LIMIT) ? limHit :
               (cfg.method == METH_GT) ? gtHit : 1'b0;

endmodule

// File: hdl/sld_fb_decode.sv
// Encoder feedback decoder: quadrature 1x/2x/4x or up/down pulses.
// Assumes phase pins are asynchronous; they are synchronised here.
`timescale 1ns/100ps
module sld_fb_decode import sld_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration
  input wire logic [1:0] fbMode,
  input wire logic fbDirB,
  // Encoder pins
  input wire logic fbPhaseA,
  input wire logic fbPhaseB,
  // Count events
  output sld_fb_evt_t evt
);

  logic aS1_r, aS2_r, bS1_r, bS2_r, aP_r, bP_r;
  sld_fb_evt_t evt_r;

  // ----------------------------------------------------------------
  // Synchronise and remember previous sample
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aS1_r <= 1'b0;
      aS2_r <= 1'b0;
      bS1_r <= 1'b0;
      bS2_r <= 1'b0;
      aP_r <= 1'b0;
      bP_r <= 1'b0;
    end else begin
      aS1_r <= fbPhaseA;
      aS2_r <= aS1_r;
      bS1_r <= fbPhaseB;
      bS2_r <= bS1_r;
      aP_r <= aS2_r;
      bP_r <= bS2_r;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Direction bit swaps which phase counts forward
  wire x = fbDirB ? bS2_r : aS2_r;
  wire y = fbDirB ? aS2_r : bS2_r;
  wire chX = x ^ (fbDirB ? bP_r : aP_r);
  wire chY = y ^ (fbDirB ? aP_r : bP_r);
  wire bothCh = chX & chY;
  wire fwdX = x != y;
  wire fwdY = x == y;
  logic upN, dnN;

  // Count selection per input mode
  always_comb begin
    upN = 1'b0;
    dnN = 1'b0;
    case (fbMode)
      EIM_X1: begin
        upN = chX & x & !y;
        dnN = chX & !x & !y;
      end
      EIM_X2: begin
        upN = chX & fwdX;
        dnN = chX & !fwdX;
      end
      EIM_X4: begin
        upN = (chX & fwdX) | (chY & fwdY);
        dnN = (chX & !fwdX) | (chY & !fwdY);
      end
      EIM_UPDN: begin
        upN = chX & x;
        dnN = chY & y;
      end
      default: begin
        upN = 1'b0;
        dnN = 1'b0;
      end
    endcase
  end

  // Error cycles are not counted: direction is unknown
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evt_r <= '0;
    end else begin
      evt_r.up <= upN & !bothCh;
      evt_r.dn <= dnN & !bothCh;
      evt_r.err <= bothCh;
    end
  end

  assign evt = evt_r;

endmodule

// File: hdl/sld_pkg.sv
// Shared constants and types for the soft limit and step loss axis block.
// Assumes a single 100 MHz reference clock and an AHB-Lite register bus.
package sld_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_PERIOD_NS = 1000;
  localparam int STEP_CYCLES = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;
  localparam int DECEL_STEPS = 8;
  localparam int DECEL_STRETCH_NS = 160;
  localparam int DECEL_STRETCH = DECEL_STRETCH_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ENV2 = 8'h00;
  localparam logic [7:0] OFS_ENV4 = 8'h04;
  localparam logic [7:0] OFS_CMP1 = 8'h08;
  localparam logic [7:0] OFS_CMP2 = 8'h0C;
  localparam logic [7:0] OFS_CMP3 = 8'h10;
  localparam logic [7:0] OFS_IRQEN = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_ERRST = 8'h1C;
  localparam logic [7:0] OFS_POS = 8'h20;
  localparam logic [7:0] OFS_DEFL = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int C1S_POS = 2;
  localparam int C1D_POS = 5;
  localparam int C2S_POS = 10;
  localparam int C2D_POS = 13;
  localparam int C3S_POS = 18;
  localparam int C3D_POS = 21;
  localparam int EIM_POS = 20;
  localparam int EDIR_POS = 22;
  localparam int ESEE_POS = 16;
  localparam int IRQ_CMP3_POS = 10;
  localparam int CMD_DIR_POS = 8;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] METH_LIMIT = 3'h6;
  localparam logic [2:0] METH_GT = 3'h5;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_IMMED = 2'h1;
  localparam logic [1:0] ACT_DECEL = 2'h2;
  localparam logic [1:0] EIM_X1 = 2'h0;
  localparam logic [1:0] EIM_X2 = 2'h1;
  localparam logic [1:0] EIM_X4 = 2'h2;
  localparam logic [1:0] EIM_UPDN = 2'h3;
  localparam logic [7:0] CMD_STOP = 8'h49;
  localparam logic [7:0] CMD_CONST_A = 8'h50;
  localparam logic [7:0] CMD_CONST_B = 8'h51;
  localparam logic [7:0] CMD_HIGH_A = 8'h52;
  localparam logic [7:0] CMD_HIGH_B = 8'h53;
  localparam logic [7:0] CMD_DEFL_CLR = 8'h22;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic up;
    logic dn;
    logic err;
  } sld_fb_evt_t;

  typedef struct packed {
    logic [2:0] method;
    logic [1:0] action;
  } sld_cmp_cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL} sld_state_t;

endpackage

// File: verif/sld_axis_ctrl_tb.sv
// Self-checking bench for the axis block with a motor model.
// Assumes zero-wait bus slave and 100-cycle step period.
`timescale 1ns/100ps
module sld_axis_ctrl_tb import sld_pkg::*; ;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, stepOut, dirOut, busy, intReq_n;
  logic phaseA, phaseB;
  logic jog = 1'b0, lose = 1'b0, glitch = 1'b0, upDown = 1'b0;
  int errors = 0;
  int n_compared = 0;
  int nSteps = 0;

  // Free-running 100 MHz clock
  initial begin
    forever #5 ref_clk = !ref_clk;
  end

  // Step pulses as the motor driver sees them
  always @(posedge ref_clk) begin
    if (stepOut === 1'b1) nSteps <= nSteps + 1;
  end

  sld_axis_ctrl sld_axis_ctrl_i (.ref_clk(ref_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .stepOut(stepOut), .dirOut(dirOut), .busy(busy),
    .fbPhaseA(phaseA), .fbPhaseB(phaseB), .intReq_n(intReq_n));

  sld_motor_model sld_motor_model_i (.ref_clk(ref_clk),
    .stepIn(stepOut), .dirIn(dirOut), .jog(jog), .jogDir(1'b1),
    .lose(lose), .glitch(glitch), .upDown(upDown),
    .phaseA(phaseA), .phaseB(phaseB));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One single transfer; waits on the slave, never on a cycle count
  task automatic bus(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, ofs, d, v);
  endtask

  task automatic rdchk(input string what, input logic [7:0] ofs,
                       input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, ofs, 32'h0, v);
    chk(what, exp, v & msk);
  endtask

  // Start a move, check acceptance, then wait for the axis to rest
  task automatic run(input logic [31:0] c, input logic moves);
    int n;
    n = 0;
    wr(OFS_CMD, c);
    repeat (3) @(posedge ref_clk);
    chk("busy", {31'h0, moves}, {31'h0, busy});
    while (busy !== 1'b0 && n < 8000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("idle", 32'h0, {31'h0, busy});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk("intReq_n", 32'h1, {31'h0, intReq_n});
    chk("hresp", 32'h0, {31'h0, hresp});
    rdchk("status", OFS_ERRST, 32'hFFFF_FFFF, 32'h0);
    rdchk("env4 readback", OFS_ENV4, 32'hFFFF_FFFF, 32'h0);
    rdchk("unmapped", 8'hFC, 32'hFFFF_FFFF, 32'h0);
  endtask

  task automatic t_limits;
    wr(OFS_ENV2, 32'h0020_0000);
    wr(OFS_ENV4, 32'h0000_3838);
    wr(OFS_CMP1, 32'h0000_0003);
    wr(OFS_CMP2, 32'hFFFF_FFFD);
    run(32'h0000_0150, 1'b1);
    chk("dirOut", 32'h1, {31'h0, dirOut});
    rdchk("position", OFS_POS, 32'hFFFF_FFFF, 32'h3);
    rdchk("status", OFS_ERRST, 32'h1, 32'h1);
    run(32'h0000_0150, 1'b0);
    run(32'h0000_0050, 1'b1);
    chk("dirOut", 32'h0, {31'h0, dirOut});
    rdchk("position", OFS_POS, 32'hFFFF_FFFF, 32'hFFFF_FFFD);
    rdchk("status", OFS_ERRST, 32'h2, 32'h2);
    rdchk("deflection", OFS_DEFL, 32'hFFFF_FFFF, 32'h0);
    chk("steps", 32'h9, 32'(nSteps));
  endtask

  // Decel adds eight steps past the limit; constant speed does not
  task automatic t_decel;
    wr(OFS_ENV4, 32'h0000_5858);
    wr(OFS_CMP1, 32'h0);
    run(32'h0000_0152, 1'b1);
    rdchk("position", OFS_POS, 32'hFFFF_FFFF, 32'h8);
    run(32'h0000_0050, 1'b1);
    rdchk("position", OFS_POS, 32'hFFFF_FFFF, 32'hFFFF_FFFD);
    wr(OFS_CMP2, 32'hFFFF_FFF6);
    run(32'h0000_0053, 1'b1);
    rdchk("position", OFS_POS, 32'hFFFF_FFFF, 32'hFFFF_FFEE);
  endtask

  // Four forward quarter turns with A leading, in every decode mode
  task automatic t_modes;
    logic [31:0] e;
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(OFS_ENV2, (32'(m) << 20) | (32'(d) << 22));
        upDown <= (m == 3);
        wr(OFS_CMD, 32'h22);
        repeat (4) begin
          @(posedge ref_clk);
          jog <= 1'b1;
          @(posedge ref_clk);
          jog <= 1'b0;
          repeat (16) @(posedge ref_clk);
        end
        e = (m == 0) ? 32'h1 : (m == 1) ? 32'h2 : 32'h4;
        e = (d == 1) ? e : -e;
        rdchk("deflection", OFS_DEFL, 32'hFFFF_FFFF, e);
      end
    end
  endtask

  task automatic t_loss;
    wr(OFS_ENV4, 32'h0036_0000);
    wr(OFS_CMP3, 32'h2);
    wr(OFS_IRQEN, 32'h0000_0400);
    wr(OFS_CMD, 32'h22);
    rdchk("status", OFS_ERRST, 32'h4, 32'h4);
    lose <= 1'b1;
    run(32'h0000_0150, 1'b1);
    repeat (2) @(posedge ref_clk);
    chk("intReq_n", 32'h0, {31'h0, intReq_n});
    rdchk("status", OFS_ERRST, 32'h4, 32'h4);
    rdchk("deflection", OFS_DEFL, 32'hFFFF_FFFF, 32'h3);
    wr(OFS_CMD, 32'h22);
    rdchk("status", OFS_ERRST, 32'h4, 32'h4);
    rdchk("deflection", OFS_DEFL, 32'hFFFF_FFFF, 32'h0);
    lose <= 1'b0;
  endtask

  task automatic t_fberr;
    chk("intReq_n", 32'h1, {31'h0, intReq_n});
    @(posedge ref_clk);
    glitch <= 1'b1;
    @(posedge ref_clk);
    glitch <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("intReq_n", 32'h0, {31'h0, intReq_n});
    rdchk("status", OFS_ERRST, 32'h1_0000, 32'h1_0000);
  endtask

  // Stop command halts a constant-speed move before its first step
  task automatic t_stop;
    wr(OFS_ENV4, 32'h0);
    wr(OFS_CMD, 32'h0000_0151);
    repeat (3) @(posedge ref_clk);
    chk("busy", 32'h1, {31'h0, busy});
    wr(OFS_CMD, 32'h0000_0049);
    repeat (2) @(posedge ref_clk);
    chk("busy", 32'h0, {31'h0, busy});
    rdchk("position", OFS_POS, 32'hFFFF_FFFF, 32'hFFFF_FFF1);
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_limits;
    t_decel;
    t_modes;
    t_loss;
    t_fberr;
    t_stop;
    stop_test;
  end

  // Watchdog, well beyond the roughly 6500 cycles the tests need
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    stop_test;
  end
endmodule

// File: verif/sld_motor_model.sv
// Stepper driver and shaft encoder model for the axis block.
// Assumes one-cycle step pulses on the axis reference clock.
`timescale 1ns/100ps
module sld_motor_model (
  // Clock and motor side
  input wire logic ref_clk,
  input wire logic stepIn,
  input wire logic dirIn,
  // Bench controls
  input wire logic jog,
  input wire logic jogDir,
  input wire logic lose,
  input wire logic glitch,
  input wire logic upDown,
  // Encoder pins
  output logic phaseA,
  output logic phaseB
);
  // ------------------------------------------------------------
  // Shaft state
  // ------------------------------------------------------------
  logic [1:0] quarter = 2'h0;
  logic [2:0] hold = 3'h0;
  logic pulA = 1'b0;
  logic pulB = 1'b0;
  logic move;
  logic fwd;

  // Lost steps never reach the encoder; jog turns the shaft by hand
  assign move = (stepIn && !lose) || jog;
  assign fwd = jog ? jogDir : dirIn;
  // Phase A leads while turning forward; pulses idle low
  assign phaseA = upDown ? pulA : quarter[0] ^ quarter[1];
  assign phaseB = upDown ? pulB : quarter[1];

  // Glitch flips both phases in one step, a fault the bench asks for
  always @(posedge ref_clk) begin
    if (glitch) begin
      quarter <= quarter + 2'h2;
      pulA <= 1'b1;
      pulB <= 1'b1;
      hold <= 3'h4;
    end else if (move) begin
      quarter <= fwd ? quarter + 2'h1 : quarter - 2'h1;
      pulA <= fwd;
      pulB <= !fwd;
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
      if (hold == 3'h1) begin
        pulA <= 1'b0;
        pulB <= 1'b0;
      end
    end
  end
endmodule
